// ### design/rbq_filter_bank.sv
// record path biquad bank: twelve sections shared by four channels
// assumes samples and host writes come from logic on the same clock
`timescale 1ns/100ps
module rbq_filter_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic cfgWrite,
  input wire logic [1:0] cfgAllocation,
  input wire logic cfgTwoChannel,
  input wire logic cfgBankSwitch,
  input wire logic coefWrite,
  input wire logic coefBank,
  input wire logic [7:0] coefPage,
  input wire logic [6:0] coefReg,
  input wire logic [rbq_pkg::DATA_W-1:0] coefData,
  input wire logic sampleValid,
  input wire logic [rbq_pkg::CHAN_COUNT-1:0][rbq_pkg::DATA_W-1:0] sampleIn,
  output logic sampleReady,
  output logic sampleOutValid,
  output logic [rbq_pkg::CHAN_COUNT-1:0][rbq_pkg::DATA_W-1:0] sampleOut,
  output logic [1:0] biquadAllocationSelect,
  output logic activeBank
);
  import rbq_pkg::*;

  rbq_state_t state;
  logic twoChannel;
  logic bankSwitch;
  logic [3:0] sec;
  logic [3:0] lastSec;
  logic [CHAN_COUNT-1:0][DATA_W-1:0] work;
  logic [CHAN_COUNT-1:0][DATA_W-1:0] next_work;
  logic [DATA_W-1:0] coef [0:1][0:SEC_COUNT-1][0:COEF_COUNT-1];
  logic signed [DATA_W-1:0] histX1 [0:SEC_COUNT-1];
  logic signed [DATA_W-1:0] histX2 [0:SEC_COUNT-1];
  logic signed [DATA_W-1:0] histY1 [0:SEC_COUNT-1];
  logic signed [DATA_W-1:0] histY2 [0:SEC_COUNT-1];
  logic signed [DATA_W-1:0] secIn;
  logic signed [DATA_W-1:0] secOut;
  logic [1:0] chan;
  logic accept;
  logic [6:0] coefOffset;
  logic [3:0] decSec;
  logic [2:0] decSlot;
  logic decValid;

  function automatic logic [3:0] last_section(input logic [1:0] alloc);
    logic [3:0] last;
    last = LAST_SEC_THREE;
    unique case (alloc)
      ALLOC_ONE: last = LAST_SEC_ONE;
      ALLOC_TWO: last = LAST_SEC_TWO;
      ALLOC_THREE: last = LAST_SEC_THREE;
      ALLOC_BYPASS: last = LAST_SEC_ONE;
    endcase
    return last;
  endfunction : last_section

  assign accept = (state == ST_IDLE) && sampleValid;
  // sections interleave channels: section s feeds channel s mod 4
  assign chan = sec[1:0];
  assign secIn = $signed(work[chan]);

  // coefficient address decode
  always_comb begin
    coefOffset = coefReg - GROUP_BASE;
    decSlot = 3'((coefOffset % GROUP_BYTES) / WORD_BYTES);
    decSec = 4'(coefOffset / GROUP_BYTES);
    if (coefPage == PAGE_HIGH) begin
      decSec = decSec + SECS_PER_PAGE;
    end
    decValid = (coefReg >= GROUP_BASE) && (coefOffset[1:0] == 2'b00)
        && ((coefPage == PAGE_LOW) || (coefPage == PAGE_HIGH));
  end

  always_comb begin
    next_work = work;
    next_work[chan] = secOut;
  end

  rbq_section u_section (
    .x(secIn),
    .x1(histX1[sec]),
    .x2(histX2[sec]),
    .y1(histY1[sec]),
    .y2(histY2[sec]),
    .numeratorCoeffZero(coef[activeBank][sec][K_N0]),
    .numeratorCoeffOne(coef[activeBank][sec][K_N1]),
    .numeratorCoeffTwo(coef[activeBank][sec][K_N2]),
    .denominatorCoeffOne(coef[activeBank][sec][K_D1]),
    .denominatorCoeffTwo(coef[activeBank][sec][K_D2]),
    .y(secOut)
  );

  // configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      biquadAllocationSelect <= ALLOC_RESET;
      twoChannel <= 1'b0;
      bankSwitch <= 1'b0;
    end else if (cfgWrite) begin
      biquadAllocationSelect <= cfgAllocation;
      twoChannel <= cfgTwoChannel;
      bankSwitch <= cfgBankSwitch;
    end
  end

  // coefficient storage, two banks per section
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int b = 0; b < 2; b++) begin
        for (int s = 0; s < SEC_COUNT; s++) begin
          for (int k = 0; k < COEF_COUNT; k++) begin
            coef[b][s][k] <= (k == 0) ? N0_RESET : COEF_ZERO_RESET;
          end
        end
      end
    end else if (coefWrite && decValid) begin
      coef[coefBank][decSec][decSlot] <= coefData;
    end
  end

  // per-section history
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int s = 0; s < SEC_COUNT; s++) begin
        histX1[s] <= '0;
        histX2[s] <= '0;
        histY1[s] <= '0;
        histY2[s] <= '0;
      end
    end else if (state == ST_RUN) begin
      histX2[sec] <= histX1[sec];
      histX1[sec] <= secIn;
      histY2[sec] <= histY1[sec];
      histY1[sec] <= secOut;
    end
  end

  // sequencer: one section per cycle in ascending order
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      sec <= 4'h0;
      lastSec <= 4'h0;
      work <= '0;
      sampleOut <= '0;
      sampleOutValid <= 1'b0;
      sampleReady <= 1'b1;
      activeBank <= 1'b0;
    end else begin
      sampleOutValid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (sampleValid) begin
            if (biquadAllocationSelect == ALLOC_BYPASS) begin
              sampleOut <= sampleIn;
              sampleOutValid <= 1'b1;
            end else begin
              work <= sampleIn;
              sec <= 4'h0;
              lastSec <= last_section(biquadAllocationSelect);
              // bank only changes between samples
              activeBank <= twoChannel & bankSwitch;
              sampleReady <= 1'b0;
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          work <= next_work;
          if (sec == lastSec) begin
            sampleOut <= next_work;
            sampleOutValid <= 1'b1;
            sampleReady <= 1'b1;
            state <= ST_IDLE;
          end else begin
            sec <= sec + 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  a_bypass_passthru: assert property (@(posedge clock) disable iff (rst)
    accept && biquadAllocationSelect == ALLOC_BYPASS
      |=> sampleOutValid && sampleOut == $past(sampleIn))
    else $error("bypass did not pass sample in one cycle");

  a_one_stage_time: assert property (@(posedge clock) disable iff (rst)
    accept && biquadAllocationSelect == ALLOC_ONE |-> ##5 sampleOutValid)
    else $error("one-section sweep took wrong time");

  a_two_stage_time: assert property (@(posedge clock) disable iff (rst)
    accept && biquadAllocationSelect == ALLOC_TWO
      |=> !sampleOutValid [*8] ##1 sampleOutValid)
    else $error("two-section sweep took wrong time");

  a_three_stage_time: assert property (@(posedge clock) disable iff (rst)
    accept && biquadAllocationSelect == ALLOC_THREE
      |=> (!sampleOutValid && !sampleReady) [*8] ##5 sampleOutValid && sampleReady)
    else $error("three-section sweep took wrong time");

  a_alloc_reset: assert property (@(posedge clock)
    $past(rst) && rst == 1'b0 |-> biquadAllocationSelect == ALLOC_TWO)
    else $error("allocation not at two sections after reset");

  a_sec_bound: assert property (@(posedge clock) disable iff (rst)
    state == ST_RUN |-> sec < 4'hC && lastSec <= LAST_SEC_THREE)
    else $error("section index beyond twelve");

  a_bank_hold: assert property (@(posedge clock) disable iff (rst)
    state == ST_RUN && $past(state) == ST_RUN |-> $stable(activeBank))
    else $error("bank changed during a sweep");

  a_cascade_order: assert property (@(posedge clock) disable iff (rst)
    state == ST_RUN && $past(state) == ST_RUN |-> sec == $past(sec) + 4'h1)
    else $error("sections not swept in ascending order");

  a_bank_select: assert property (@(posedge clock) disable iff (rst)
    accept && biquadAllocationSelect != ALLOC_BYPASS
      |=> activeBank == ($past(twoChannel) & $past(bankSwitch)))
    else $error("active bank not taken from switch bit");
endmodule : rbq_filter_bank

// ### design/rbq_pkg.sv
// constants and types of the record biquad filter bank
// assumes one clock domain; users import rbq_pkg::*
package rbq_pkg;
  localparam int SEC_COUNT = 12;
  localparam int CHAN_COUNT = 4;
  localparam int COEF_COUNT = 5;
  localparam int DATA_W = 32;
  localparam int ACC_W = 72;
  localparam int FRAC_BITS = 31;
  localparam logic [ACC_W-1:0] ROUND_HALF = 72'h00_0000_0000_4000_0000;
  // allocation field values
  localparam logic [1:0] ALLOC_BYPASS = 2'h0;
  localparam logic [1:0] ALLOC_ONE = 2'h1;
  localparam logic [1:0] ALLOC_TWO = 2'h2;
  localparam logic [1:0] ALLOC_THREE = 2'h3;
  localparam logic [1:0] ALLOC_RESET = ALLOC_TWO;
  // last section index swept for each allocation
  localparam logic [3:0] LAST_SEC_ONE = 4'h3;
  localparam logic [3:0] LAST_SEC_TWO = 4'h7;
  localparam logic [3:0] LAST_SEC_THREE = 4'hB;
  // coefficient slots inside a section
  localparam logic [2:0] K_N0 = 3'h0;
  localparam logic [2:0] K_N1 = 3'h1;
  localparam logic [2:0] K_N2 = 3'h2;
  localparam logic [2:0] K_D1 = 3'h3;
  localparam logic [2:0] K_D2 = 3'h4;
  localparam logic [DATA_W-1:0] N0_RESET = 32'h7FFFFFFF;
  localparam logic [DATA_W-1:0] COEF_ZERO_RESET = 32'h00000000;
  // coefficient register layout
  localparam logic [7:0] PAGE_LOW = 8'h08;
  localparam logic [7:0] PAGE_HIGH = 8'h09;
  localparam logic [6:0] GROUP_BASE = 7'h08;
  localparam logic [6:0] GROUP_BYTES = 7'h14;
  localparam logic [6:0] WORD_BYTES = 7'h04;
  localparam logic [3:0] SECS_PER_PAGE = 4'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } rbq_state_t;
endpackage : rbq_pkg

// ### design/rbq_section.sv
// one biquad section evaluated in a single combinational pass
// assumes the caller holds the section history and coefficients
`timescale 1ns/100ps
module rbq_section (
  input wire logic signed [rbq_pkg::DATA_W-1:0] x,
  input wire logic signed [rbq_pkg::DATA_W-1:0] x1,
  input wire logic signed [rbq_pkg::DATA_W-1:0] x2,
  input wire logic signed [rbq_pkg::DATA_W-1:0] y1,
  input wire logic signed [rbq_pkg::DATA_W-1:0] y2,
  input wire logic signed [rbq_pkg::DATA_W-1:0] numeratorCoeffZero,
  input wire logic signed [rbq_pkg::DATA_W-1:0] numeratorCoeffOne,
  input wire logic signed [rbq_pkg::DATA_W-1:0] numeratorCoeffTwo,
  input wire logic signed [rbq_pkg::DATA_W-1:0] denominatorCoeffOne,
  input wire logic signed [rbq_pkg::DATA_W-1:0] denominatorCoeffTwo,
  output logic signed [rbq_pkg::DATA_W-1:0] y
);
  import rbq_pkg::*;

  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] scaled;
  logic [ACC_W-DATA_W:0] upper;

  always_comb begin
    // feedback terms enter with plus sign, denominator is 2^31 - 2*d1 - d2
    // operands widened first so no product is cut to 32 bits
    acc = ACC_W'(numeratorCoeffZero) * ACC_W'(x)
        + ((ACC_W'(numeratorCoeffOne) * ACC_W'(x1)) <<< 1)
        + ACC_W'(numeratorCoeffTwo) * ACC_W'(x2)
        + ((ACC_W'(denominatorCoeffOne) * ACC_W'(y1)) <<< 1)
        + ACC_W'(denominatorCoeffTwo) * ACC_W'(y2)
        + $signed(ROUND_HALF);
    scaled = acc >>> FRAC_BITS;
    upper = scaled[ACC_W-1:DATA_W-1];
    if (&upper || ~|upper) begin
      y = scaled[DATA_W-1:0];
    end else if (scaled[ACC_W-1]) begin
      y = {1'b1, {(DATA_W-1){1'b0}}};
    end else begin
      y = {1'b0, {(DATA_W-1){1'b1}}};
    end
  end
endmodule : rbq_section

// ### verif/rbq_filter_bank_tb.sv
// self-checking bench for the record biquad filter bank
// assumes rbq_sample_source drives the sample stream
`timescale 1ns/100ps
module rbq_filter_bank_tb;
  import rbq_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfgWrite = 1'b0;
  logic [1:0] cfgAllocation = 2'h0;
  logic cfgTwoChannel = 1'b0;
  logic cfgBankSwitch = 1'b0;
  logic coefWrite = 1'b0;
  logic coefBank = 1'b0;
  logic [7:0] coefPage = 8'h00;
  logic [6:0] coefReg = 7'h00;
  logic [DATA_W-1:0] coefData = '0;
  logic sampleValid, sampleReady, sampleOutValid, activeBank;
  logic [CHAN_COUNT-1:0][DATA_W-1:0] sampleIn, sampleOut, last;
  logic [1:0] biquadAllocationSelect;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 50;
  always #20 clock = ~clock;
  rbq_filter_bank uut (.clock, .rst, .cfgWrite, .cfgAllocation, .cfgTwoChannel,
    .cfgBankSwitch, .coefWrite, .coefBank, .coefPage, .coefReg, .coefData, .sampleValid,
    .sampleIn, .sampleReady, .sampleOutValid, .sampleOut, .biquadAllocationSelect,
    .activeBank);
  rbq_sample_source src (.clock, .sampleReady, .sampleValid, .sampleIn);
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] half(input logic [31:0] x);
    return $signed(x + 32'h1) >>> 1;
  endfunction : half
  task automatic cfg(input logic [1:0] a, input logic two, input logic sw);
    @(negedge clock);
    {cfgWrite, cfgAllocation, cfgTwoChannel, cfgBankSwitch} = {1'b1, a, two, sw};
    @(negedge clock);
    cfgWrite = 1'b0;
    check("allocation", {30'h0, biquadAllocationSelect}, {30'h0, a});
  endtask : cfg
  task automatic wr(input logic b, input logic [7:0] p, input logic [6:0] r, input logic [31:0] v);
    @(negedge clock);
    {coefWrite, coefBank, coefPage, coefReg, coefData} = {1'b1, b, p, r, v};
    @(negedge clock);
    coefWrite = 1'b0;
  endtask : wr
  // hv holds the count of half-gain sections per channel, two bits each
  task automatic run(input logic [1:0] a, input logic [7:0] hv, input logic tap);
    logic [CHAN_COUNT-1:0][DATA_W-1:0] d;
    logic [31:0] e;
    logic ok;
    int n;
    for (int c = 0; c < CHAN_COUNT; c++) d[c] = $random(seed) >>> 3;
    src.send(d, ok);
    check("ready busy", {31'h0, sampleReady}, {31'h0, a == ALLOC_BYPASS});
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (n < 20 && sampleOutValid !== 1'b1);
    check("latency", n, (a == ALLOC_BYPASS) ? 1 : 4 * a + 1);
    check("ready idle", {31'h0, sampleReady}, 32'h1);
    for (int c = 0; c < CHAN_COUNT; c++) begin
      e = d[c];
      repeat (hv[2*c+:2]) e = half(e);
      if (tap && c == 3) e = half(d[c] + last[c]);
      check("sample", sampleOut[c], e);
    end
    last = d;
    if (!ok || n >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask : run
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    check("reset allocation", {30'h0, biquadAllocationSelect}, {30'h0, ALLOC_RESET});
    check("reset bank", {31'h0, activeBank}, 32'h0);
    run(ALLOC_TWO, 8'h00, 1'b0);
    wr(1'b0, PAGE_LOW, 7'h08, 32'h40000000);
    wr(1'b0, PAGE_LOW, 7'h58, 32'h40000000);
    wr(1'b0, PAGE_HIGH, 7'h30, 32'h40000000);
    // out-of-map writes must leave section 1 untouched
    wr(1'b0, 8'h0A, 7'h1C, 32'h0);
    wr(1'b0, PAGE_LOW, 7'h1E, 32'h0);
    for (int a = 0; a < 4; a++) begin
      cfg(a[1:0], 1'b0, 1'b0);
      run(a[1:0], {6'h0, a[1:0]}, 1'b0);
    end
    wr(1'b1, PAGE_LOW, 7'h1C, 32'h40000000);
    cfg(ALLOC_ONE, 1'b1, 1'b1);
    run(ALLOC_ONE, 8'h04, 1'b0);
    check("bank", {31'h0, activeBank}, 32'h1);
    cfg(ALLOC_ONE, 1'b1, 1'b0);
    run(ALLOC_ONE, 8'h01, 1'b0);
    cfg(ALLOC_ONE, 1'b0, 1'b1);
    run(ALLOC_ONE, 8'h01, 1'b0);
    check("bank", {31'h0, activeBank}, 32'h0);
    wr(1'b0, PAGE_LOW, 7'h44, 32'h40000000);
    wr(1'b0, PAGE_LOW, 7'h48, 32'h20000000);
    run(ALLOC_ONE, 8'h01, 1'b1);
    run(ALLOC_ONE, 8'h01, 1'b1);
    print_verdict();
  end
endmodule : rbq_filter_bank_tb

// ### verif/rbq_sample_source.sv
// upstream sample source feeding the record biquad bank
// assumes the bank's clock and a registered sampleReady
`timescale 1ns/100ps
module rbq_sample_source (
  input wire logic clock,
  input wire logic sampleReady,
  output logic sampleValid,
  output logic [rbq_pkg::CHAN_COUNT-1:0][rbq_pkg::DATA_W-1:0] sampleIn
);
  import rbq_pkg::*;
  logic taken;
  initial begin
    sampleValid = 1'b0;
    sampleIn = '0;
  end
  always @(posedge clock) taken <= sampleValid && sampleReady;
  // released data toggles so a stale set never passes for a fresh one
  always @(negedge clock) begin
    if (taken) begin
      sampleValid <= 1'b0;
      sampleIn <= ~sampleIn;
    end
  end
  task automatic send(input logic [CHAN_COUNT-1:0][DATA_W-1:0] d, output logic ok);
    int i;
    @(negedge clock);
    sampleValid = 1'b1;
    sampleIn = d;
    ok = 1'b0;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge clock);
      #1;
      ok = taken;
    end
  endtask : send
endmodule : rbq_sample_source
